//--- core/svm_supply_monitor.sv
// Behaviour
// (R1) While the main supply is below the power-on-reset level the block holds the no-supply state with everything, the real-time clock included, off.
// The code drives only rtc_enable and por_reset_n low there; the monitor comparator stays enabled and the sense buffers follow their setting.
// (R2) A main supply above the power-on-reset level moves the block from no-supply to backup.
// (R3) From backup the block moves to off once the main supply is above the low-system threshold.
// (R4) A main supply below the low-system threshold in active, sleep or off sends the block back to backup.
// (R5) The low-system and start thresholds come only from the one-time-programmable settings and no register write can change them.
// (R6) During power-up the monitor comparator uses the start threshold and off-to-startup is allowed only while it reports the supply above it.
// (R7) When start-up completes the monitor comparator is switched off, and software may then set a new threshold and enable it again.
// (R8) A falling main supply is checked against the power-on-reset level once every millisecond.
// (R9) The monitor comparator uses one threshold code for both directions, with no hysteresis, so it can raise repeated interrupts at the threshold.
// (R10) After a monitor interrupt no new monitor interrupt is raised for the debounce interval.
// (R11) When the sense-buffer setting is one the internal buffers of the sense path are enabled.
// (R12) Comparator outputs are synchronised to the clock before they steer the state machine or the interrupts.
`timescale 1ns/1ps
`include "svm_regs.svh"

module svm_supply_monitor
  import svm_pkg::*;
#(
  parameter int unsigned POR_SAMPLE_CYCLES = `SVM_POR_SAMPLE_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = `SVM_DEBOUNCE_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire svm_cmp_t cmp_in,
  input wire svm_thr_t otp_low_system_threshold,
  input wire svm_thr_t otp_startup_supply_threshold,
  input wire logic otp_sense_buffer,
  input wire logic on_request,
  input wire logic sleep_request,
  input wire logic startup_done,
  output svm_ana_ctrl_t ana_ctrl,
  output svm_pstate_t power_state,
  output logic rtc_enable,
  output logic por_reset_n,
  output logic irq
);

  typedef struct packed {
    svm_pstate_t state;
    logic sw_mode;
    svm_thr_t mon_thr;
    logic mon_en;
    logic mon_prev;
    logic mon_prev_valid;
    logic [`SVM_DEB_W-1:0] deb_cnt;
    logic [`SVM_IRQ_W-1:0] irq_status;
    logic [`SVM_IRQ_W-1:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    svm_ana_ctrl_t ana;
    logic rtc_en;
    logic por_rstn;
  } svm_state_t;

  svm_state_t r_reg;
  svm_state_t r_next;
  svm_cmp_t cmp_sync;
  logic por_tick;

  // Comparators are asynchronous to pclk
  svm_sync #(
    .WIDTH(3)
  ) u_cmp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(cmp_in),
    .q(cmp_sync)
  ); // R12

  svm_tick_div #(
    .PERIOD(POR_SAMPLE_CYCLES)
  ) u_por_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(por_tick)
  ); // R8

  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic rd_status_done;
  logic mon_active;
  logic mon_edge;
  logic [`SVM_IRQ_W-1:0] events;
  logic [31:0] rd_value;
  logic rd_hit;

  always_comb
  begin
    setup_phase = psel && !penable && !r_reg.pready;
    access_done = psel && penable && r_reg.pready;
    wr_done = access_done && pwrite;
    rd_status_done = access_done && !pwrite && (paddr == `SVM_ADDR_IRQ_STATUS);
    mon_active = r_reg.sw_mode && r_reg.mon_en;
    events = '0;
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      `SVM_ADDR_STATE:
      begin
        rd_value[2:0] = r_reg.state;
        rd_value[`SVM_STATE_SWMODE_BIT] = r_reg.sw_mode;
        rd_value[`SVM_STATE_CMP_LSB +: 3] = cmp_sync;
      end
      `SVM_ADDR_MON:
      begin
        rd_value[`SVM_THR_W-1:0] = r_reg.mon_thr;
        rd_value[`SVM_MON_EN_BIT] = r_reg.mon_en;
      end
      `SVM_ADDR_IRQ_STATUS:
        rd_value[`SVM_IRQ_W-1:0] = r_reg.irq_status;
      `SVM_ADDR_IRQ_MASK:
        rd_value[`SVM_IRQ_W-1:0] = r_reg.irq_mask;
      `SVM_ADDR_OTP:
      begin
        rd_value[`SVM_THR_W-1:0] = otp_low_system_threshold;
        rd_value[`SVM_OTP_START_LSB +: `SVM_THR_W] = otp_startup_supply_threshold;
        rd_value[`SVM_OTP_BUF_BIT] = otp_sense_buffer;
      end
      default:
        rd_hit = 1'b0;
    endcase

    r_next = r_reg;

    // APB: answer registered in the setup cycle, pready high for one access cycle
    r_next.pready = setup_phase;
    if (setup_phase)
    begin
      r_next.pslverr = !rd_hit;
      r_next.prdata = pwrite ? 32'h0000_0000 : rd_value;
    end
    else if (access_done)
    begin
      r_next.pslverr = 1'b0;
      r_next.prdata = 32'h0000_0000;
    end

    // Thresholds of the low-system and start comparators are not writable
    if (wr_done && paddr == `SVM_ADDR_MON)
    begin
      r_next.mon_thr = pwdata[`SVM_THR_W-1:0];
      r_next.mon_en = pwdata[`SVM_MON_EN_BIT];
    end // R5 R7
    if (wr_done && paddr == `SVM_ADDR_IRQ_MASK)
      r_next.irq_mask = pwdata[`SVM_IRQ_W-1:0];

    // Power state machine
    unique case (r_reg.state)
      SVM_NOSUPPLY:
      begin
        if (cmp_sync.por_above)
          r_next.state = SVM_BACKUP; // R2
      end
      SVM_BACKUP:
      begin
        if (cmp_sync.low_above)
          r_next.state = SVM_OFF; // R3
      end
      SVM_OFF:
      begin
        if (!cmp_sync.low_above)
          r_next.state = SVM_BACKUP; // R4
        else if (on_request && cmp_sync.mon_above)
          r_next.state = SVM_STARTUP; // R6
      end
      SVM_STARTUP:
      begin
        if (!cmp_sync.low_above)
          r_next.state = SVM_BACKUP; // R4
        else if (startup_done)
        begin
          r_next.state = SVM_ACTIVE;
          r_next.sw_mode = 1'b1;
          r_next.mon_en = 1'b0; // R7
          events[`SVM_IRQ_STARTED] = 1'b1;
        end
      end
      SVM_ACTIVE:
      begin
        if (!cmp_sync.low_above)
          r_next.state = SVM_BACKUP; // R4
        else if (sleep_request)
          r_next.state = SVM_SLEEP;
      end
      SVM_SLEEP:
      begin
        if (!cmp_sync.low_above)
          r_next.state = SVM_BACKUP; // R4
        else if (!sleep_request)
          r_next.state = SVM_ACTIVE;
      end
      // Unused codes fall back to the safe state
      default:
        r_next.state = SVM_NOSUPPLY; // R1
    endcase

    // Falling supply is only looked at on the sampling tick
    if (r_reg.state != SVM_NOSUPPLY && por_tick && !cmp_sync.por_above)
      r_next.state = SVM_NOSUPPLY; // R8

    if (r_next.state == SVM_BACKUP && r_reg.state != SVM_BACKUP)
      events[`SVM_IRQ_BACKUP] = 1'b1;
    if (r_next.state == SVM_NOSUPPLY || r_next.state == SVM_BACKUP)
      r_next.sw_mode = 1'b0;

    // Monitor comparator: a change of level while software has it enabled (sw_mode and mon_en) is an event if the debounce count is zero
    mon_edge = mon_active && r_reg.mon_prev_valid && (cmp_sync.mon_above != r_reg.mon_prev); // R9
    r_next.mon_prev = cmp_sync.mon_above;
    r_next.mon_prev_valid = mon_active;
    if (r_reg.deb_cnt != '0)
      r_next.deb_cnt = r_reg.deb_cnt - `SVM_DEB_W'(1);
    else if (mon_edge)
    begin
      events[`SVM_IRQ_MON] = 1'b1;
      r_next.deb_cnt = `SVM_DEB_W'(DEBOUNCE_CYCLES);
    end // R10

    // Read clears only the bits that were returned; a new event wins
    if (rd_status_done)
      r_next.irq_status = r_reg.irq_status & ~r_reg.prdata[`SVM_IRQ_W-1:0];
    r_next.irq_status = r_next.irq_status | events;
    r_next.irq = |(r_next.irq_status & r_next.irq_mask);

    // Analog settings: start threshold until start-up is done
    r_next.ana.low_code = otp_low_system_threshold; // R5
    r_next.ana.mon_code = r_next.sw_mode ? r_next.mon_thr : otp_startup_supply_threshold; // R6
    r_next.ana.mon_comp_enable = r_next.sw_mode ? r_next.mon_en : 1'b1; // R6 R7
    r_next.ana.sense_buffer_enable = otp_sense_buffer; // R11

    r_next.rtc_en = (r_next.state != SVM_NOSUPPLY); // R1
    r_next.por_rstn = (r_next.state != SVM_NOSUPPLY); // R1
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg <= '0;
      r_reg.state <= SVM_NOSUPPLY; // R1
      r_reg.mon_thr <= `SVM_MON_THR_RST;
      r_reg.irq_mask <= `SVM_IRQ_MASK_RST;
    end
    else
      r_reg <= r_next;
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign ana_ctrl = r_reg.ana;
  assign power_state = r_reg.state;
  assign rtc_enable = r_reg.rtc_en;
  assign por_reset_n = r_reg.por_rstn;
  assign irq = r_reg.irq;

endmodule

//--- pkg/svm_regs.svh
`ifndef SVM_REGS_SVH
`define SVM_REGS_SVH

// Threshold code width of the analog comparators
`define SVM_THR_W 7

// Register byte addresses
`define SVM_ADDR_STATE 8'h00
`define SVM_ADDR_MON 8'h04
`define SVM_ADDR_IRQ_STATUS 8'h08
`define SVM_ADDR_IRQ_MASK 8'h0C
`define SVM_ADDR_OTP 8'h10

// Field positions
`define SVM_MON_EN_BIT 7
`define SVM_STATE_SWMODE_BIT 3
`define SVM_STATE_CMP_LSB 4
`define SVM_OTP_START_LSB 8
`define SVM_OTP_BUF_BIT 16
`define SVM_IRQ_W 3
`define SVM_IRQ_MON 0
`define SVM_IRQ_BACKUP 1
`define SVM_IRQ_STARTED 2

// Reset values
`define SVM_MON_THR_RST 7'h00
`define SVM_IRQ_MASK_RST 3'h0

// Timing
`define SVM_CLK_PERIOD_NS 8
`define SVM_POR_SAMPLE_MS 1
`define SVM_DEBOUNCE_US 125
`define SVM_POR_SAMPLE_CYCLES ((`SVM_POR_SAMPLE_MS * 1000000) / `SVM_CLK_PERIOD_NS)
`define SVM_DEBOUNCE_CYCLES ((`SVM_DEBOUNCE_US * 1000) / `SVM_CLK_PERIOD_NS)
`define SVM_DEB_W 16

`endif

//--- pkg/svm_pkg.sv
`include "svm_regs.svh"

package svm_pkg;

  typedef logic [`SVM_THR_W-1:0] svm_thr_t;

  typedef enum logic [2:0] {
    SVM_NOSUPPLY,
    SVM_BACKUP,
    SVM_OFF,
    SVM_STARTUP,
    SVM_ACTIVE,
    SVM_SLEEP
  } svm_pstate_t;

  // Comparator outputs, one bit each: 1 = supply above threshold
  typedef struct packed {
    logic mon_above;
    logic low_above;
    logic por_above;
  } svm_cmp_t;

  // Settings driven to the analog comparators
  typedef struct packed {
    logic sense_buffer_enable;
    logic mon_comp_enable;
    svm_thr_t mon_code;
    svm_thr_t low_code;
  } svm_ana_ctrl_t;

endpackage

//--- core/svm_sync.sv
`timescale 1ns/1ps

module svm_sync
  import svm_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } svm_sync_state_t;

  svm_sync_state_t r_reg;
  svm_sync_state_t r_next;

  always_comb
  begin
    r_next.meta = d;
    r_next.stable = r_reg.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign q = r_reg.stable;

endmodule

//--- core/svm_tick_div.sv
`timescale 1ns/1ps

module svm_tick_div
  import svm_pkg::*;
#(
  parameter int unsigned PERIOD = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);

  localparam int unsigned W = $clog2(PERIOD + 1);

  typedef struct packed {
    logic [W-1:0] count;
    logic tick;
  } svm_div_state_t;

  svm_div_state_t r_reg;
  svm_div_state_t r_next;

  always_comb
  begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.count == W'(PERIOD - 1))
    begin
      r_next.count = '0;
      r_next.tick = 1'b1;
    end
    else
      r_next.count = r_reg.count + W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign tick = r_reg.tick;

endmodule

//--- verification/svm_monitor.sv
`timescale 1ns/1ps
module svm_monitor
  import svm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire svm_cmp_t cmp_in,
  input wire svm_thr_t otp_low_system_threshold,
  input wire svm_thr_t otp_startup_supply_threshold,
  input wire logic otp_sense_buffer,
  input wire svm_ana_ctrl_t ana_ctrl,
  input wire svm_pstate_t power_state,
  input wire logic rtc_enable,
  input wire logic por_reset_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic run;
  assign run = power_state inside {SVM_OFF, SVM_STARTUP, SVM_ACTIVE, SVM_SLEEP};
  chk_nosup_dark: assert property (
    power_state == SVM_NOSUPPLY |-> !rtc_enable && !por_reset_n)
    else $error("outputs live without supply");
  chk_por_rise: assert property (
    cmp_in.por_above[*3] ##0 power_state == SVM_NOSUPPLY |=> power_state == SVM_BACKUP)
    else $error("no backup after supply rise");
  chk_backup_off: assert property (
    (cmp_in.low_above && cmp_in.por_above)[*3] ##0 power_state == SVM_BACKUP
    |=> power_state == SVM_OFF)
    else $error("no off after low level rise");
  chk_low_fall: assert property (
    (!cmp_in.low_above)[*3] |=> !run)
    else $error("run state below low level");
  chk_otp_only: assert property (
    $past(presetn) |-> ana_ctrl.low_code == otp_low_system_threshold
    && ana_ctrl.sense_buffer_enable == otp_sense_buffer)
    else $error("otp setting not applied");
  chk_start_code: assert property (
    power_state inside {SVM_OFF, SVM_STARTUP}
    |-> ana_ctrl.mon_comp_enable && ana_ctrl.mon_code == otp_startup_supply_threshold)
    else $error("start threshold not used");
  chk_start_gate: assert property (
    $rose(power_state == SVM_STARTUP) |-> $past(cmp_in.mon_above, 3))
    else $error("start without monitor above");
  chk_mon_off: assert property (
    $past(power_state) == SVM_STARTUP && power_state == SVM_ACTIVE
    |-> ##[0:1] !ana_ctrl.mon_comp_enable)
    else $error("monitor left on after start");
  chk_por_sample: assert property (
    $fell(cmp_in.por_above) |-> ##[1:26] power_state == SVM_NOSUPPLY)
    else $error("supply loss not sampled");
  chk_sync_delay: assert property (
    $rose(cmp_in.por_above) && power_state == SVM_NOSUPPLY
    |-> ##2 power_state == SVM_NOSUPPLY)
    else $error("comparator not synchronised");
endmodule

bind svm_supply_monitor svm_monitor u_mon (
  .pclk(pclk),
  .presetn(presetn),
  .cmp_in(cmp_in),
  .otp_low_system_threshold(otp_low_system_threshold),
  .otp_startup_supply_threshold(otp_startup_supply_threshold),
  .otp_sense_buffer(otp_sense_buffer),
  .ana_ctrl(ana_ctrl),
  .power_state(power_state),
  .rtc_enable(rtc_enable),
  .por_reset_n(por_reset_n)
);

//--- verification/tb_top.sv
`timescale 1ns/1ps
`include "svm_regs.svh"
module tb_top
  import svm_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic on_request, sleep_request, startup_done, rtc_enable, por_reset_n, irq;
  logic otp_sense_buffer;
  svm_thr_t otp_low_system_threshold, otp_startup_supply_threshold;
  svm_cmp_t cmp_in;
  svm_ana_ctrl_t ana_ctrl;
  svm_pstate_t power_state;
  int error_cnt, total_checks, cyc;

  svm_supply_monitor #(
    .POR_SAMPLE_CYCLES(20),
    .DEBOUNCE_CYCLES(10)
  ) u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cmp_in(cmp_in),
    .otp_low_system_threshold(otp_low_system_threshold),
    .otp_startup_supply_threshold(otp_startup_supply_threshold),
    .otp_sense_buffer(otp_sense_buffer),
    .on_request(on_request),
    .sleep_request(sleep_request),
    .startup_done(startup_done),
    .ana_ctrl(ana_ctrl),
    .power_state(power_state),
    .rtc_enable(rtc_enable),
    .por_reset_n(por_reset_n),
    .irq(irq)
  );

  initial
  begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    // Only the bench timeout ends this wait
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(0, a, 0);
    chk(nm, rd, e);
  endtask

  task wst(input svm_pstate_t s, input string nm);
    int n;
    n = 0;
    while (power_state !== s && n++ < 40)
      @(posedge pclk);
    chk(nm, power_state, s);
  endtask

  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    cmp_in = '0;
    on_request = 0;
    sleep_request = 0;
    startup_done = 0;
    otp_low_system_threshold = 7'h2A;
    otp_startup_supply_threshold = 7'h55;
    otp_sense_buffer = 1;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    chk("dark", {rtc_enable, por_reset_n}, 0);
    chk("ana", ana_ctrl, {2'b11, 7'h55, 7'h2A});
    apb(1, `SVM_ADDR_OTP, 32'hFFFFFFFF);
    rc(`SVM_ADDR_OTP, 32'h0001552A, "otp");
    rc(`SVM_ADDR_MON, 0, "mon0");
    apb(1, `SVM_ADDR_MON, 32'h00000085);
    apb(0, 8'h14, 0);
    chk("slverr", serr, 1);
    apb(1, `SVM_ADDR_IRQ_MASK, 7);
    cmp_in.por_above <= 1;
    wst(SVM_BACKUP, "backup");
    chk("live", {rtc_enable, por_reset_n}, 3);
    repeat (2) @(posedge pclk);
    chk("irq", irq, 1);
    rc(`SVM_ADDR_IRQ_STATUS, 2, "st_bk");
    @(posedge pclk);
    chk("irqclr", irq, 0);
    cmp_in.low_above <= 1;
    wst(SVM_OFF, "off");
    on_request <= 1;
    repeat (8) @(posedge pclk);
    chk("gated", power_state, SVM_OFF);
    cmp_in.mon_above <= 1;
    wst(SVM_STARTUP, "start");
    startup_done <= 1;
    wst(SVM_ACTIVE, "active");
    startup_done <= 0;
    rc(`SVM_ADDR_MON, 32'h05, "mon_off");
    rc(`SVM_ADDR_STATE, 32'h7C, "state");
    rc(`SVM_ADDR_IRQ_STATUS, 4, "st_up");
    apb(1, `SVM_ADDR_MON, 32'hA5);
    repeat (2) @(posedge pclk);
    chk("mon", ana_ctrl[14:7], 8'hA5);
    cmp_in.mon_above <= 0;
    repeat (4) @(posedge pclk);
    rc(`SVM_ADDR_IRQ_STATUS, 1, "ev1");
    cmp_in.mon_above <= 1;
    repeat (3) @(posedge pclk);
    rc(`SVM_ADDR_IRQ_STATUS, 0, "deb");
    repeat (10) @(posedge pclk);
    apb(1, `SVM_ADDR_IRQ_MASK, 6);
    cmp_in.mon_above <= 0;
    repeat (4) @(posedge pclk);
    chk("mask", irq, 0);
    rc(`SVM_ADDR_IRQ_STATUS, 1, "ev2");
    sleep_request <= 1;
    wst(SVM_SLEEP, "sleep");
    cmp_in.low_above <= 0;
    wst(SVM_BACKUP, "lowfall");
    cmp_in.por_above <= 0;
    wst(SVM_NOSUPPLY, "por");
    @(posedge pclk);
    chk("dark2", {rtc_enable, por_reset_n}, 0);
    report_and_stop();
  end
endmodule
